// ==== logic/lsp_pkg.sv ====
// Constants, field layouts and host register map of the line serial port.
// Function
// - Command byte: read flag, six-bit address, ignored bit
// - Eight write data bits follow, LSB first
// - Control byte: clears, length, loopbacks, all-ones
// - Set clear bit suppresses its interrupt source
// - Writing clear drops interrupt; reading does not
// - Writing clear also resets status code
// - Read bits 0-4: loss, fault, line length
// - Read bits 5-7 carry the encoded status
// - Data output released after last read bit
// - Host may join data in and out
// - Edge select picks serial and rail edges
// - Host starts every transfer by lowering select
// - Alarm pulls low on change until cleared
// - Alarm is open drain, pulls low only
// - Grounded alternate clock disables all-ones transmit
// - Sample on rising clock; select rises later
// - Both loopbacks written: reset, force loss high
// - Last read bit held to 16th/17th edge
`default_nettype none
package lsp_pkg;
   // Serial frame layout.
   localparam logic [5:0] DEV_ADDR     = 6'h10;
   localparam int         CMD_BITS     = 8;
   localparam int         FRAME_BITS   = 16;
   localparam logic [4:0] CNT_CMD_LAST = 5'h07;
   localparam logic [4:0] CNT_WR_LAST  = 5'h0f;
   localparam logic [4:0] CNT_RD_FIRST = 5'h08;
   localparam logic [4:0] CNT_RD_END   = 5'h10;
   localparam logic [4:0] CNT_MAX      = 5'h11;
   // Control byte fields.
   localparam int BIT_CLR_LOSS  = 0;
   localparam int BIT_CLR_FAULT = 1;
   localparam int BIT_LEN_LO    = 2;
   localparam int BIT_REMOTE    = 5;
   localparam int BIT_LOCAL     = 6;
   localparam int BIT_ALL_ONES  = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Host timing: serial clock half period and the gap after the last write bit.
   localparam int CLK_PERIOD_NS     = 10;
   localparam int SCLK_HALF_NS      = 80;
   localparam int CS_HOLD_NS        = 50;
   localparam int SCLK_HALF_CYC     = SCLK_HALF_NS / CLK_PERIOD_NS;
   localparam int CS_HOLD_CYC       = (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Host register map (byte addresses).
   localparam logic [3:0] REG_TXDATA = 4'h0;
   localparam logic [3:0] REG_CTRL   = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int HC_START = 0;
   localparam int HC_READ  = 1;
   localparam int HC_EDGE  = 2;
   localparam int HC_ADDR  = 8;
endpackage
`default_nettype wire

// ==== logic/lsp_if.sv ====
// Serial control port wires between the host and the line interface device.
`default_nettype none
interface lsp_if;
   logic cs_n;
   logic sclk;
   logic sdi_o;
   logic sdi_oe;
   logic sdo_o;
   logic sdo_oe;
   logic irq_oe;
   logic data_line;
   logic irq_n_line;
   // One shared data wire with a pull-up; both ends may drive it in turn.
   assign data_line  = sdo_oe ? sdo_o : (sdi_oe ? sdi_o : 1'b1);
   // Open-drain alarm: pulled up unless the device sinks it.
   assign irq_n_line = ~irq_oe;
   modport dev  (input cs_n, sclk, data_line, output sdo_o, sdo_oe, irq_oe);
   modport host (output cs_n, sclk, sdi_o, sdi_oe, input data_line, irq_n_line);
endinterface
`default_nettype wire

// ==== logic/lsp_device.sv ====
// Device end of the serial control port: control byte, status word and alarm.
`default_nettype none
module lsp_device (
   input  wire logic  CLK,
   input  wire logic  RESET,
   lsp_if.dev         LINK,
   input  wire logic  SIGNAL_LOSS,
   input  wire logic  DRIVER_ACTIVITY_FAULT,
   input  wire logic  EDGE_SELECT,
   input  wire logic  ALT_CLOCK_PRESENT,
   input  wire logic  RECOVERED_CLOCK,
   input  wire logic  RX_POS_RAW,
   input  wire logic  RX_NEG_RAW,
   output logic       RX_POSITIVE_RAIL,
   output logic       RX_NEGATIVE_RAIL,
   output logic [2:0] LINE_LENGTH_SEL,
   output logic       REMOTE_LOOPBACK,
   output logic       LOCAL_LOOPBACK,
   output logic       ALL_ONES_TRANSMIT,
   output logic       SIGNAL_LOSS_IND
);
   // Status code {bit5, bit6, bit7}: change flags take precedence over mode codes.
   function automatic logic [2:0] lsp_code(input logic pl, input logic pd, input logic rl,
                                           input logic ll, input logic ao);
      if (pl && pd) lsp_code = 3'h7;
      else if (pl) lsp_code = 3'h6;
      else if (pd) lsp_code = 3'h5;
      else if (rl) lsp_code = 3'h4;
      else lsp_code = {1'b0, ll, ao};
   endfunction

   logic [2:0]  cs_s_ff;
   logic [2:0]  sck_s_ff;
   logic [1:0]  sdi_s_ff;
   logic [2:0]  los_s_ff;
   logic [2:0]  dpm_s_ff;
   logic [2:0]  rck_s_ff;
   logic [1:0]  rx_positive_rail_s_ff;
   logic [1:0]  rx_negative_rail_s_ff;
   logic [1:0]  esel_s_ff;
   logic [1:0]  alt_s_ff;
   logic        active_ff;
   logic [4:0]  cnt_ff;
   logic [15:0] shreg_ff;
   logic [7:0]  ctrl_ff;
   logic        pend_los_ff;
   logic        pend_dpm_ff;
   logic        forced_loss_ff;
   logic        sdo_ff;
   logic        sdo_oe_ff;
   logic        irq_oe_ff;
   logic        all_ones_ff;
   logic        rx_positive_rail_ff;
   logic        rx_negative_rail_ff;
   logic        nxt_pend_los;
   logic        nxt_pend_dpm;

   // Two flip-flops on every foreign input; the third stage only feeds edge detectors.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         cs_s_ff   <= 3'h7;
         sck_s_ff  <= 3'h0;
         sdi_s_ff  <= 2'h0;
         los_s_ff  <= 3'h0;
         dpm_s_ff  <= 3'h0;
         rck_s_ff  <= 3'h0;
         rx_positive_rail_s_ff <= 2'h0;
         rx_negative_rail_s_ff <= 2'h0;
         esel_s_ff <= 2'h0;
         alt_s_ff  <= 2'h0;
      end else begin
         cs_s_ff   <= {cs_s_ff[1:0], LINK.cs_n};
         sck_s_ff  <= {sck_s_ff[1:0], LINK.sclk};
         sdi_s_ff  <= {sdi_s_ff[0], LINK.data_line};
         los_s_ff  <= {los_s_ff[1:0], SIGNAL_LOSS};
         dpm_s_ff  <= {dpm_s_ff[1:0], DRIVER_ACTIVITY_FAULT};
         rck_s_ff  <= {rck_s_ff[1:0], RECOVERED_CLOCK};
         rx_positive_rail_s_ff <= {rx_positive_rail_s_ff[0], RX_POS_RAW};
         rx_negative_rail_s_ff <= {rx_negative_rail_s_ff[0], RX_NEG_RAW};
         esel_s_ff <= {esel_s_ff[0], EDGE_SELECT};
         alt_s_ff  <= {alt_s_ff[0], ALT_CLOCK_PRESENT};
      end
   end

   logic       cs_n_s;
   logic       cs_fall;
   logic       sck_rise;
   logic       sck_fall;
   logic       esel;
   logic       cmd_read;
   logic       cmd_hit;
   logic       wr_commit;
   logic [7:0] wr_data;
   logic       wr_reset;
   logic [7:0] status;
   logic [2:0] rd_idx;

   assign cs_n_s   = cs_s_ff[1];
   assign cs_fall  = cs_s_ff[2] & ~cs_s_ff[1];
   assign sck_rise = ~sck_s_ff[2] & sck_s_ff[1];
   assign sck_fall = sck_s_ff[2] & ~sck_s_ff[1];
   assign esel     = esel_s_ff[1];
   // Command byte fields, valid once eight bits have arrived; bit 7 is ignored.
   assign cmd_read = shreg_ff[0];
   assign cmd_hit  = (shreg_ff[6:1] == lsp_pkg::DEV_ADDR);
   // The eighth data bit is still on the pin at the commit edge.
   assign wr_data   = {sdi_s_ff[1], shreg_ff[14:8]};
   assign wr_commit = active_ff & sck_rise & (cnt_ff == lsp_pkg::CNT_WR_LAST) & ~cmd_read & cmd_hit;
   assign wr_reset  = wr_data[lsp_pkg::BIT_REMOTE] & wr_data[lsp_pkg::BIT_LOCAL];
   assign rd_idx    = 3'(cnt_ff - lsp_pkg::CNT_RD_FIRST);

   // Status word as the host reads it.
   always_comb begin
      logic [2:0] code;
      code = lsp_code(pend_los_ff, pend_dpm_ff, ctrl_ff[lsp_pkg::BIT_REMOTE],
                      ctrl_ff[lsp_pkg::BIT_LOCAL], all_ones_ff);
      status    = 8'h00;
      status[0] = los_s_ff[1] | forced_loss_ff;
      status[1] = dpm_s_ff[1];
      status[4:2] = ctrl_ff[4:2];
      status[5] = code[2];
      status[6] = code[1];
      status[7] = code[0];
   end

   // Frame tracking: a high select always aborts, so a truncated frame commits nothing.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         active_ff <= 1'b0;
         cnt_ff    <= 5'h00;
         shreg_ff  <= 16'h0000;
      end else if (cs_n_s) begin
         active_ff <= 1'b0;
      end else if (cs_fall) begin
         active_ff <= 1'b1;
         cnt_ff    <= 5'h00;
      end else if (active_ff && sck_rise && cnt_ff != lsp_pkg::CNT_MAX) begin
         cnt_ff <= cnt_ff + 5'h01;
         if (cnt_ff < 5'(lsp_pkg::FRAME_BITS)) begin
            shreg_ff[cnt_ff[3:0]] <= sdi_s_ff[1];
         end
      end
   end

   // Read output: the edge select decides whether bits change on falling or rising edges.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sdo_ff    <= 1'b0;
         sdo_oe_ff <= 1'b0;
      end else if (cs_n_s || !active_ff || !cmd_read || !cmd_hit) begin
         sdo_oe_ff <= 1'b0;
      end else if ((esel && sck_fall) || (!esel && sck_rise)) begin
         if (cnt_ff >= lsp_pkg::CNT_RD_FIRST && cnt_ff < lsp_pkg::CNT_RD_END) begin
            sdo_ff    <= status[rd_idx];
            sdo_oe_ff <= 1'b1;
         end else if (cnt_ff >= lsp_pkg::CNT_RD_END) begin
            sdo_oe_ff <= 1'b0;
         end
      end
   end

   // Control register; writing both loopbacks resets instead of storing.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_ff        <= lsp_pkg::CTRL_RESET;
         forced_loss_ff <= 1'b0;
      end else if (wr_commit) begin
         if (wr_reset) begin
            ctrl_ff        <= lsp_pkg::CTRL_RESET;
            forced_loss_ff <= 1'b1;
         end else begin
            ctrl_ff        <= wr_data;
            forced_loss_ff <= 1'b0;
         end
      end
   end

   // Change flags: a change in the clearing cycle still sets the flag unless suppressed.
   always_comb begin
      logic sup_los;
      logic sup_dpm;
      logic signal_loss_irq_clear;
      logic driver_fault_irq_clear;
      sup_los = wr_commit ? (wr_data[lsp_pkg::BIT_CLR_LOSS] & ~wr_reset) : ctrl_ff[lsp_pkg::BIT_CLR_LOSS];
      sup_dpm = wr_commit ? (wr_data[lsp_pkg::BIT_CLR_FAULT] & ~wr_reset) : ctrl_ff[lsp_pkg::BIT_CLR_FAULT];
      signal_loss_irq_clear = wr_commit & (wr_data[lsp_pkg::BIT_CLR_LOSS] | wr_reset);
      driver_fault_irq_clear = wr_commit & (wr_data[lsp_pkg::BIT_CLR_FAULT] | wr_reset);
      nxt_pend_los = pend_los_ff;
      nxt_pend_dpm = pend_dpm_ff;
      if ((los_s_ff[1] ^ los_s_ff[2]) && !sup_los) nxt_pend_los = 1'b1;
      else if (signal_loss_irq_clear) nxt_pend_los = 1'b0;
      if ((dpm_s_ff[1] ^ dpm_s_ff[2]) && !sup_dpm) nxt_pend_dpm = 1'b1;
      else if (driver_fault_irq_clear) nxt_pend_dpm = 1'b0;
   end

   // Pending flags and the open-drain alarm enable; reads never touch them.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pend_los_ff <= 1'b0;
         pend_dpm_ff <= 1'b0;
         irq_oe_ff   <= 1'b0;
      end else begin
         pend_los_ff <= nxt_pend_los;
         pend_dpm_ff <= nxt_pend_dpm;
         irq_oe_ff   <= nxt_pend_los | nxt_pend_dpm;
      end
   end

   // Line-side outputs; all-ones needs the alternate clock and yields to remote loopback.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         all_ones_ff     <= 1'b0;
         SIGNAL_LOSS_IND <= 1'b0;
      end else begin
         all_ones_ff     <= ctrl_ff[lsp_pkg::BIT_ALL_ONES] & alt_s_ff[1] & ~ctrl_ff[lsp_pkg::BIT_REMOTE];
         SIGNAL_LOSS_IND <= los_s_ff[1] | forced_loss_ff;
      end
   end

   // Receive rails change on the edge opposite to the one where they must be valid.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rx_positive_rail_ff <= 1'b0;
         rx_negative_rail_ff <= 1'b0;
      end else if ((esel && !rck_s_ff[2] && rck_s_ff[1]) || (!esel && rck_s_ff[2] && !rck_s_ff[1])) begin
         rx_positive_rail_ff <= rx_positive_rail_s_ff[1];
         rx_negative_rail_ff <= rx_negative_rail_s_ff[1];
      end
   end

   assign LINK.sdo_o      = sdo_ff;
   assign LINK.sdo_oe     = sdo_oe_ff;
   assign LINK.irq_oe     = irq_oe_ff;
   assign RX_POSITIVE_RAIL  = rx_positive_rail_ff;
   assign RX_NEGATIVE_RAIL  = rx_negative_rail_ff;
   assign LINE_LENGTH_SEL   = ctrl_ff[lsp_pkg::BIT_LEN_LO +: 3];
   assign REMOTE_LOOPBACK   = ctrl_ff[lsp_pkg::BIT_REMOTE];
   assign LOCAL_LOOPBACK    = ctrl_ff[lsp_pkg::BIT_LOCAL];
   assign ALL_ONES_TRANSMIT = all_ones_ff;
endmodule
`default_nettype wire

// ==== logic/lsp_host.sv ====
// Host end: Avalon-MM register slave that runs serial read and write frames.
`default_nettype none
module lsp_host (
   input  wire logic  CLK,
   input  wire logic  RESET,
   lsp_if.host        LINK,
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST
);
   typedef enum logic [4:0] {
      HS_IDLE  = 5'b00001,
      HS_SETUP = 5'b00010,
      HS_LOW   = 5'b00100,
      HS_HIGH  = 5'b01000,
      HS_END   = 5'b10000
   } lsp_hstate_t;

   lsp_hstate_t state_ff;
   logic [7:0]  txdata_ff;
   logic [7:0]  rxdata_ff;
   logic [5:0]  addr_ff;
   logic        read_ff;
   logic        edge_ff;
   logic [3:0]  idx_ff;
   logic [3:0]  tmr_ff;
   logic        cs_n_ff;
   logic        sclk_ff;
   logic        sdi_ff;
   logic        sdi_oe_ff;
   logic [1:0]  dat_s_ff;
   logic [1:0]  irq_s_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        start;
   logic [15:0] frame;
   logic        tmr_done;
   logic        rd_bit;

   assign start    = AVS_WRITE && !wait_ff && AVS_ADDRESS == lsp_pkg::REG_CTRL &&
                     AVS_WRITEDATA[lsp_pkg::HC_START] && state_ff == HS_IDLE;
   assign frame    = {txdata_ff, 1'b0, addr_ff, read_ff};
   assign tmr_done = (tmr_ff == 4'h0);
   assign rd_bit   = read_ff && idx_ff >= 4'(lsp_pkg::CMD_BITS);

   // Returning data line and alarm are foreign signals: two flip-flops each.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         dat_s_ff <= 2'h3;
         irq_s_ff <= 2'h3;
      end else begin
         dat_s_ff <= {dat_s_ff[0], LINK.data_line};
         irq_s_ff <= {irq_s_ff[0], LINK.irq_n_line};
      end
   end

   // Bus slave: waitrequest drops for exactly one cycle per request.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else if ((AVS_READ || AVS_WRITE) && wait_ff) begin
         wait_ff <= 1'b0;
         case (AVS_ADDRESS)
            lsp_pkg::REG_TXDATA: rdata_ff <= {24'h000000, txdata_ff};
            lsp_pkg::REG_CTRL:   rdata_ff <= {18'h00000, addr_ff, 5'h00, edge_ff, read_ff, 1'b0};
            lsp_pkg::REG_STATUS: rdata_ff <= {15'h0000, ~irq_s_ff[1], rxdata_ff, 7'h00, state_ff != HS_IDLE};
            default:             rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         wait_ff <= 1'b1;
      end
   end

   // Register writes; configuration is frozen while a frame runs.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         txdata_ff <= 8'h00;
         addr_ff   <= lsp_pkg::DEV_ADDR;
         read_ff   <= 1'b0;
         edge_ff   <= 1'b0;
      end else if (AVS_WRITE && !wait_ff && state_ff == HS_IDLE) begin
         if (AVS_ADDRESS == lsp_pkg::REG_TXDATA) txdata_ff <= AVS_WRITEDATA[7:0];
         if (AVS_ADDRESS == lsp_pkg::REG_CTRL) begin
            addr_ff <= AVS_WRITEDATA[lsp_pkg::HC_ADDR +: 6];
            read_ff <= AVS_WRITEDATA[lsp_pkg::HC_READ];
            edge_ff <= AVS_WRITEDATA[lsp_pkg::HC_EDGE];
         end
      end
   end

   // Frame sequencer: the serial clock is a divider of CLK, one half period per phase.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_ff  <= HS_IDLE;
         idx_ff    <= 4'h0;
         tmr_ff    <= 4'h0;
         cs_n_ff   <= 1'b1;
         sclk_ff   <= 1'b0;
         sdi_ff    <= 1'b0;
         sdi_oe_ff <= 1'b0;
         rxdata_ff <= 8'h00;
      end else begin
         if (!tmr_done) tmr_ff <= tmr_ff - 4'h1;
         case (state_ff)
            HS_IDLE: begin
               if (start) begin
                  state_ff <= HS_SETUP;
                  cs_n_ff  <= 1'b0;
                  idx_ff   <= 4'h0;
                  tmr_ff   <= 4'(lsp_pkg::SCLK_HALF_CYC - 1);
               end
            end
            HS_SETUP, HS_LOW: begin
               // The setup phase also waits a half period, so the first bit leads the first rise.
               if (tmr_done) begin
                  state_ff <= HS_HIGH;
                  sclk_ff  <= 1'b1;
                  tmr_ff   <= 4'(lsp_pkg::SCLK_HALF_CYC - 1);
                  if (rd_bit && edge_ff) rxdata_ff[idx_ff[2:0]] <= dat_s_ff[1];
               end
               if (state_ff == HS_SETUP) begin
                  sdi_ff    <= frame[0];
                  sdi_oe_ff <= 1'b1;
               end
            end
            HS_HIGH: begin
               if (tmr_done) begin
                  sclk_ff <= 1'b0;
                  tmr_ff  <= 4'(lsp_pkg::SCLK_HALF_CYC - 1);
                  if (rd_bit && !edge_ff) rxdata_ff[idx_ff[2:0]] <= dat_s_ff[1];
                  if (idx_ff == 4'(lsp_pkg::FRAME_BITS - 1)) begin
                     state_ff  <= HS_END;
                     sdi_oe_ff <= 1'b0;
                  end else begin
                     state_ff <= HS_LOW;
                     idx_ff   <= idx_ff + 4'h1;
                     sdi_ff   <= frame[idx_ff + 4'h1];
                     // Release the shared line for the device's read bits.
                     sdi_oe_ff <= !(read_ff && idx_ff + 4'h1 >= 4'(lsp_pkg::CMD_BITS));
                  end
               end
            end
            HS_END: begin
               // A full half period after the last fall exceeds the select hold time.
               if (tmr_done) begin
                  state_ff <= HS_IDLE;
                  cs_n_ff  <= 1'b1;
               end
            end
            default: state_ff <= HS_IDLE;
         endcase
      end
   end

   assign LINK.cs_n   = cs_n_ff;
   assign LINK.sclk   = sclk_ff;
   assign LINK.sdi_o  = sdi_ff;
   assign LINK.sdi_oe = sdi_oe_ff;
   assign AVS_READDATA    = rdata_ff;
   assign AVS_WAITREQUEST = wait_ff;
endmodule
`default_nettype wire

// ==== test/lsp_props.sv ====
// Concurrent checks on the serial control port wires.
`default_nettype none
module lsp_props (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic irq_oe,
   input wire logic data_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sclk_ff;
   logic [4:0] cnt_ff;
   logic [7:0] cmd_ff;
   logic       rise;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   assign rise = sclk & ~sclk_ff;
   // Count clock rises in a frame and keep the command byte, so the checks know the frame kind.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sclk_ff <= 1'b0;
         cnt_ff  <= 5'h00;
         cmd_ff  <= 8'h00;
      end else begin
         sclk_ff <= sclk;
         if (cs_n) begin
            cnt_ff <= 5'h00;
            cmd_ff <= 8'h00;
         end else if (rise && cnt_ff != 5'h1f) begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff < 5'h08) cmd_ff[cnt_ff[2:0]] <= data_line;
         end
      end
   end
   a_sdo_only_read : assert property ($rose(sdo_oe) |-> !cs_n && cnt_ff >= 5'h08 && cmd_ff[0] &&
      cmd_ff[6:1] == lsp_pkg::DEV_ADDR) else $error("data output driven outside a matching read");
   a_sdo_idle_off : assert property (cs_n [*5] |-> !sdo_oe) else $error("data output driven while idle");
   a_sdo_edge_stable : assert property (sdo_oe && $past(sdo_oe) && sclk != sclk_ff |-> $stable(sdo_o))
      else $error("data output changed at a serial clock edge");
   a_sdi_read_off : assert property (!cs_n && cmd_ff[0] && cnt_ff >= 5'h09 |-> !sdi_oe)
      else $error("host drives data during read phase");
   a_no_contention : assert property (!(sdo_oe && sdi_oe)) else $error("both ends drive data");
   a_cs_hold_last : assert property (rise && cnt_ff == 5'h0f |-> !cs_n [*5])
      else $error("select rose too soon after last bit");
   a_cs_frame_low : assert property ($fell(cs_n) |-> !cs_n [*8]) else $error("select pulse too short");
   a_irq_idle_held : assert property (irq_oe && cs_n && $past(cs_n) |=> irq_oe)
      else $error("alarm dropped without a write");
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench: host and device ends joined, driven over Avalon-MM.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset, av_read, av_write, av_wait, loss, fault, edge_sel, alt, rclk, rxp, rxn;
   logic        rlb, llb, aot, lossind, rx_pos, rx_neg, rclk_q, esel_q;
   logic [3:0]  av_address;
   logic [31:0] av_wdata, av_rdata, q;
   logic [2:0]  len;
   logic [7:0]  c, cm, rb;
   logic [5:0]  fa;
   int          errors, total_checks, i, rail_n;
   lsp_if link();
   lsp_device lsp_device_inst (.CLK(clk), .RESET(reset), .LINK(link), .SIGNAL_LOSS(loss),
      .DRIVER_ACTIVITY_FAULT(fault), .EDGE_SELECT(edge_sel), .ALT_CLOCK_PRESENT(alt), .RECOVERED_CLOCK(rclk),
      .RX_POS_RAW(rxp), .RX_NEG_RAW(rxn), .RX_POSITIVE_RAIL(rx_pos), .RX_NEGATIVE_RAIL(rx_neg), .LINE_LENGTH_SEL(len),
      .REMOTE_LOOPBACK(rlb), .LOCAL_LOOPBACK(llb), .ALL_ONES_TRANSMIT(aot), .SIGNAL_LOSS_IND(lossind));
   lsp_host lsp_host_inst (.CLK(clk), .RESET(reset), .LINK(link), .AVS_ADDRESS(av_address), .AVS_READ(av_read),
      .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
   lsp_props lsp_props_inst (.CLK(clk), .RESET(reset), .cs_n(link.cs_n), .sclk(link.sclk), .sdi_oe(link.sdi_oe),
      .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .irq_oe(link.irq_oe), .data_line(link.data_line));
   // System clock and a free recovered line clock of unrelated phase.
   always #5 clk = ~clk;
   always #80 rclk = ~rclk;
   // Rail data moves just after the recovered clock edge at which it is not taken, so it is settled at the other.
   always @(posedge clk) begin
      rclk_q <= rclk;
      if (rclk != rclk_q && rclk != edge_sel) begin
         rxp <= 1'($urandom);
         rxn <= 1'($urandom);
      end
   end
   // At the edge where the rails must be valid they show the data taken at the opposite edge.
   always @(rclk) begin
      if (reset || edge_sel != esel_q) rail_n = 0;
      else if (rclk != edge_sel) rail_n++;
      if (rail_n > 2 && rclk != edge_sel) begin
         chk("rx_pos", 32'(rxp), 32'(rx_pos));
         chk("rx_neg", 32'(rxn), 32'(rx_neg));
      end
      esel_q = edge_sel;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask
   // One Avalon transfer; the request holds until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      av_address <= a;
      av_write <= wr;
      av_read <= !wr;
      av_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (av_wait !== 1'b0 && n < 100);
      r = av_rdata;
      av_read <= 1'b0;
      av_write <= 1'b0;
      if (n >= 100) chk("waitrequest", 32'h0, 32'(av_wait));
   endtask
   // One serial frame through the host, waiting on its busy flag.
   task automatic frame(input logic rd, input logic [5:0] ad, input logic [7:0] d, output logic [7:0] r);
      logic [31:0] s;
      int n;
      bus(1'b1, lsp_pkg::REG_TXDATA, {24'h0, d}, s);
      bus(1'b1, lsp_pkg::REG_CTRL, {18'h0, ad, 5'h0, edge_sel, rd, 1'b1}, s);
      n = 0;
      do begin
         bus(1'b0, lsp_pkg::REG_STATUS, 32'h0, s);
         n++;
      end while (s[0] !== 1'b0 && n < 200);
      chk("busy", 32'h0, 32'(s[0]));
      r = s[15:8];
      repeat (4) @(posedge clk);
   endtask
   task automatic wrc(input logic [7:0] v);
      frame(1'b0, lsp_pkg::DEV_ADDR, v, rb);
      cm = v;
   endtask
   task automatic rdc(input logic [7:0] e);
      frame(1'b1, lsp_pkg::DEV_ADDR, 8'h00, rb);
      chk("status", 32'(e), 32'(rb));
   endtask
   task automatic outs();
      chk("length", 32'(cm[4:2]), 32'(len));
      chk("remote", 32'(cm[5]), 32'(rlb));
      chk("local", 32'(cm[6]), 32'(llb));
      chk("all_ones", 32'(cm[7] & alt & ~cm[5]), 32'(aot));
   endtask
   // Expected status word; a change flag outranks the loopback and all-ones codes.
   function automatic logic [7:0] expst(logic [7:0] v, logic lo, logic fl, logic lc, logic fc);
      logic [2:0] k;
      k = (lc && fc) ? 3'b111 : lc ? 3'b110 : fc ? 3'b101 : v[5] ? 3'b100 : {1'b0, v[6], v[7]};
      return {k[0], k[1], k[2], v[4:2], fl, lo};
   endfunction
   // Watchdog: far beyond the expected run length.
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
   initial begin
      {clk, rclk, av_read, av_write, loss, fault, edge_sel, rxp, rxn} = '0;
      {av_address, av_wdata, cm, errors, total_checks} = '0;
      reset = 1'b1;
      alt = 1'b1;
      void'($urandom(50));
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b0, lsp_pkg::REG_CTRL, 32'h0, q);
      chk("ctrl_reset", 32'h1000, q);
      bus(1'b0, 4'hc, 32'h0, q);
      chk("unmapped", 32'h0, q);
      // Random control bytes read back; every fourth write and read pair goes to a foreign address.
      for (i = 0; i < 16; i++) begin
         c = 8'($urandom);
         if (c[6:5] == 2'b11) c[6] = 1'b0;
         fa = 6'($urandom);
         if (fa == lsp_pkg::DEV_ADDR) fa = 6'h00;
         edge_sel <= 1'($urandom);
         alt <= 1'($urandom);
         if (i % 4 == 3) begin
            frame(1'b0, fa, c, rb);
            outs();
            frame(1'b1, fa, 8'h00, rb);
            chk("foreign_read", 32'hff, 32'(rb));
         end else begin
            wrc(c);
            outs();
            alt <= 1'b1;
            rdc(expst(c, 1'b0, 1'b0, 1'b0, 1'b0));
         end
      end
      // Alarm: raise, read without clearing, clear, suppress, re-enable, both sources.
      wrc(8'h00);
      loss <= 1'b1;
      repeat (10) @(posedge clk);
      chk("alarm", 32'h0, 32'(link.irq_n_line));
      bus(1'b0, lsp_pkg::REG_STATUS, 32'h0, q);
      chk("alarm_bit", 32'h1, 32'(q[16]));
      rdc(8'h61);
      chk("alarm_read", 32'h0, 32'(link.irq_n_line));
      wrc(8'h01);
      chk("alarm_clr", 32'h1, 32'(link.irq_n_line));
      rdc(8'h01);
      loss <= 1'b0;
      repeat (10) @(posedge clk);
      chk("alarm_sup", 32'h1, 32'(link.irq_n_line));
      rdc(8'h00);
      wrc(8'h00);
      fault <= 1'b1;
      repeat (10) @(posedge clk);
      chk("alarm_fault", 32'h0, 32'(link.irq_n_line));
      rdc(8'ha2);
      loss <= 1'b1;
      repeat (10) @(posedge clk);
      rdc(8'he3);
      wrc(8'h03);
      chk("alarm_both", 32'h1, 32'(link.irq_n_line));
      rdc(8'h03);
      // Both loopbacks in one write reset the control byte and force loss high.
      loss <= 1'b0;
      wrc(8'h7c);
      cm = 8'h00;
      outs();
      chk("loss_forced", 32'h1, 32'(lossind));
      rdc(8'h03);
      wrc(8'h00);
      chk("loss_release", 32'h0, 32'(lossind));
      give_verdict();
   end
endmodule
`default_nettype wire
